/* rft_pkg.sv */
// Package with register map, field layout and timing constants of timer two
package rft_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam logic [7:0] ADDR_T1_CNT_HI = 8'h17;
  localparam logic [7:0] ADDR_T1_CNT_LO = 8'h18;
  localparam logic [7:0] ADDR_T2_CTRL = 8'h19;
  localparam logic [7:0] ADDR_T2_RELOAD_HI = 8'h1A;
  localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'h1B;
  localparam logic [7:0] ADDR_T2_CNT_HI = 8'h1C;
  localparam logic [7:0] ADDR_T2_CNT_LO = 8'h1D;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h31;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h32;
  localparam int CTRL_HALT_BIT = 7;
  localparam int CTRL_START_HI = 5;
  localparam int CTRL_START_LO = 4;
  localparam int CTRL_RELOAD_BIT = 3;
  localparam int CTRL_CLK_HI = 1;
  localparam int CTRL_CLK_LO = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hBB;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam logic [7:0] IRQ_MASK = 8'h01;
  localparam logic [1:0] START_NONE = 2'h0;
  localparam logic [1:0] START_TX_END = 2'h1;
  localparam logic [1:0] START_TRIM_NO_UF = 2'h2;
  localparam logic [1:0] START_TRIM_UF = 2'h3;
  localparam logic [1:0] CLK_FAST = 2'h0;
  localparam logic [1:0] CLK_SLOW = 2'h1;
  localparam logic [1:0] CLK_TIMER0 = 2'h2;
  localparam logic [1:0] CLK_TIMER1 = 2'h3;
  localparam int RX_HALT_BITS = 4;
  localparam logic [2:0] RX_BITS_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // Fast tick at 13.56 MHz divided by this gives about 212 kHz
  localparam int SLOW_DIV = 64;
  localparam logic [5:0] SLOW_DIV_LAST = 6'(SLOW_DIV - 1);
  typedef enum logic [1:0] {RFT_IDLE, RFT_RUN} rft_state_t;
endpackage

/* rft_sync.sv */
// Two-flop synchroniser with a rising-edge pulse on the synchronised level
`timescale 1ns/1ps
module rft_sync import rft_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Level in and out
  input wire logic din,
  output logic dout,
  output logic rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign dout = sync_reg;
  assign rise = sync_reg & ~last_reg;
endmodule

/* rft_regs.sv */
// Reload byte pair of timer two
`timescale 1ns/1ps
module rft_regs import rft_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Write port
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [DATA_W-1:0] wdata,
  // Stored value
  output logic [CNT_W-1:0] reload
);
  logic [DATA_W-1:0] hi_reg;
  logic [DATA_W-1:0] lo_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_reg <= RELOAD_RESET;
      lo_reg <= RELOAD_RESET;
    end else begin
      if (wr_hi) begin
        hi_reg <= wdata;
      end
      if (wr_lo) begin
        lo_reg <= wdata;
      end
    end
  end

  assign reload = {hi_reg, lo_reg};
endmodule

/* rft_timer_two.sv */
// Timer two of the reader frontend with timer one read-back and register port
`timescale 1ns/1ps
module rft_timer_two import rft_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  // Frontend events, same clock domain
  input wire logic fast_tick,
  input wire logic tx_done,
  input wire logic rx_bit_valid,
  input wire logic rx_frame_start,
  input wire logic timer0_underflow,
  input wire logic timer1_underflow,
  input wire logic [CNT_W-1:0] timer1_count,
  // Slow oscillator trimming pin
  input wire logic slow_osc_pin,
  // Timer two outputs
  output logic timer_two_underflow,
  output logic timer_two_running,
  // Interrupt
  output logic irq
);
  logic [DATA_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] reload_val;
  rft_state_t state_reg;
  logic [2:0] rx_bits_reg;
  logic rx_halted_reg;
  logic [5:0] div_reg;
  logic slow_tick;
  logic [IRQ_UNDERFLOW_BIT:0] irq_status_reg;
  logic [7:0] irq_enable_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic underflow_reg;
  logic osc_rise;
  logic halt_en;
  logic [1:0] start_sel;
  logic [1:0] clk_sel;
  logic reload_on_zero;
  logic tick;
  logic start_evt;
  logic stop_evt;
  logic underflow_evt;
  logic trim_mode;
  logic rx_halt_evt;

  function automatic logic sel_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    sel_hit = (a == r);
  endfunction

  // Control fields
  assign halt_en = ctrl_reg[CTRL_HALT_BIT];
  assign start_sel = ctrl_reg[CTRL_START_HI:CTRL_START_LO];
  assign reload_on_zero = ctrl_reg[CTRL_RELOAD_BIT];
  assign clk_sel = ctrl_reg[CTRL_CLK_HI:CTRL_CLK_LO];
  assign trim_mode = (start_sel == START_TRIM_NO_UF) || (start_sel == START_TRIM_UF);

  // Slow oscillator pin synchroniser
  rft_sync u_osc_sync (
    .clk(clk),
    .rstn(rstn),
    .din(slow_osc_pin),
    .dout(),
    .rise(osc_rise)
  );

  // Reload value store
  rft_regs u_reload (
    .clk(clk),
    .rstn(rstn),
    .wr_hi(wr_en && sel_hit(addr, ADDR_T2_RELOAD_HI)),
    .wr_lo(wr_en && sel_hit(addr, ADDR_T2_RELOAD_LO)),
    .wdata(wdata),
    .reload(reload_val)
  );

  // Control register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_en && sel_hit(addr, ADDR_T2_CTRL)) begin
      ctrl_reg <= wdata & CTRL_WMASK;
    end
  end

  // Slow tick divider from fast tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 6'h00;
    end else if (fast_tick) begin
      div_reg <= (div_reg == SLOW_DIV_LAST) ? 6'h00 : div_reg + 6'h01;
    end
  end
  assign slow_tick = fast_tick && (div_reg == SLOW_DIV_LAST);

  // Tick source selection
  always_comb begin
    case (clk_sel)
      CLK_FAST: tick = fast_tick;
      CLK_SLOW: tick = slow_tick;
      CLK_TIMER0: tick = timer0_underflow;
      CLK_TIMER1: tick = timer1_underflow;
      default: tick = 1'b0;
    endcase
  end

  // Start and stop events
  always_comb begin
    start_evt = 1'b0;
    stop_evt = 1'b0;
    case (start_sel)
      START_NONE: start_evt = 1'b0;
      START_TX_END: start_evt = tx_done;
      START_TRIM_NO_UF, START_TRIM_UF: begin
        start_evt = osc_rise && (state_reg == RFT_IDLE);
        stop_evt = osc_rise && (state_reg == RFT_RUN);
      end
      default: start_evt = 1'b0;
    endcase
  end

  // Received-bit counter for halt on first nibble
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_bits_reg <= RX_BITS_RESET;
      rx_halted_reg <= 1'b0;
    end else if (rx_frame_start) begin
      rx_bits_reg <= RX_BITS_RESET;
      rx_halted_reg <= 1'b0;
    end else if (rx_bit_valid && !rx_halted_reg) begin
      rx_bits_reg <= rx_bits_reg + 3'h1;
      rx_halted_reg <= (rx_bits_reg == 3'(RX_HALT_BITS - 1));
    end
  end
  assign rx_halt_evt = halt_en && !trim_mode && rx_bit_valid && !rx_halted_reg
                       && (rx_bits_reg == 3'(RX_HALT_BITS - 1));

  // Underflow happens on a tick at zero; suppressed in trim mode without underflow
  assign underflow_evt = (state_reg == RFT_RUN) && tick && (count_reg == CNT_ZERO)
                         && (start_sel != START_TRIM_NO_UF);

  // Counter and run state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= RFT_IDLE;
      count_reg <= CNT_ZERO;
    end else begin
      case (state_reg)
        RFT_IDLE: begin
          if (start_evt) begin
            count_reg <= reload_val;
            state_reg <= RFT_RUN;
          end
        end
        RFT_RUN: begin
          if (stop_evt || rx_halt_evt) begin
            state_reg <= RFT_IDLE;
          end else if (start_evt) begin
            count_reg <= reload_val;
          end else if (tick) begin
            if (count_reg != CNT_ZERO) begin
              count_reg <= count_reg - CNT_ONE;
            end else if (start_sel == START_TRIM_NO_UF) begin
              count_reg <= CNT_ZERO;
            end else if (reload_on_zero) begin
              count_reg <= reload_val;
            end else begin
              state_reg <= RFT_IDLE;
            end
          end
        end
        default: state_reg <= RFT_IDLE;
      endcase
    end
  end

  // Underflow pulse output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      underflow_reg <= 1'b0;
    end else begin
      underflow_reg <= underflow_evt;
    end
  end

  // Sticky status, set wins over clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status_reg <= '0;
    end else begin
      if (wr_en && sel_hit(addr, ADDR_IRQ_CLEAR) && wdata[IRQ_UNDERFLOW_BIT]) begin
        irq_status_reg[IRQ_UNDERFLOW_BIT] <= 1'b0;
      end
      if (underflow_evt) begin
        irq_status_reg[IRQ_UNDERFLOW_BIT] <= 1'b1;
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable_reg <= 8'h00;
    end else if (wr_en && sel_hit(addr, ADDR_IRQ_ENABLE)) begin
      irq_enable_reg <= wdata & IRQ_MASK;
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        ADDR_T1_CNT_HI: rdata_reg <= timer1_count[CNT_W-1:DATA_W];
        ADDR_T1_CNT_LO: rdata_reg <= timer1_count[DATA_W-1:0];
        ADDR_T2_CTRL: rdata_reg <= ctrl_reg;
        ADDR_T2_RELOAD_HI: rdata_reg <= reload_val[CNT_W-1:DATA_W];
        ADDR_T2_RELOAD_LO: rdata_reg <= reload_val[DATA_W-1:0];
        ADDR_T2_CNT_HI: rdata_reg <= count_reg[CNT_W-1:DATA_W];
        ADDR_T2_CNT_LO: rdata_reg <= count_reg[DATA_W-1:0];
        ADDR_IRQ_STATUS: rdata_reg <= {7'h00, irq_status_reg[IRQ_UNDERFLOW_BIT]};
        ADDR_IRQ_ENABLE: rdata_reg <= irq_enable_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign timer_two_underflow = underflow_reg;
  assign timer_two_running = (state_reg == RFT_RUN);
  assign irq = irq_status_reg[IRQ_UNDERFLOW_BIT] & irq_enable_reg[IRQ_UNDERFLOW_BIT];
endmodule

/* rft_timer_two_chk.sv */
// Checker bound to the timer two ports
`timescale 1ns/1ps
module rft_timer_two_chk import rft_pkg::*; (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rdata,
  // Events and timer outputs
  input wire logic fast_tick,
  input wire logic tx_done,
  input wire logic timer0_underflow,
  input wire logic timer1_underflow,
  input wire logic timer_two_underflow,
  input wire logic timer_two_running,
  input wire logic irq
);
  logic [7:0] ctrl_reg;
  logic en_reg;
  logic tick_reg;
  // Shadow of control and enable, selected tick of the last cycle, with the fast tick recorded when slow is selected
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
      en_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      if (wr_en && addr == ADDR_T2_CTRL) ctrl_reg <= wdata & CTRL_WMASK;
      if (wr_en && addr == ADDR_IRQ_ENABLE) en_reg <= wdata[IRQ_UNDERFLOW_BIT];
      tick_reg <= ctrl_reg[1] ? (ctrl_reg[0] ? timer1_underflow : timer0_underflow) : fast_tick;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata outside read");
  property p_start; tx_done && ctrl_reg[5:4] == START_TX_END |=> timer_two_running; endproperty
  a_start: assert property (p_start) else $error("no start after tx end");
  property p_stop;
    timer_two_underflow && !ctrl_reg[CTRL_RELOAD_BIT] && ctrl_reg[5:4] == START_TX_END
      && !$past(tx_done) |-> !timer_two_running;
  endproperty
  a_stop: assert property (p_stop) else $error("running after underflow");
  property p_restart;
    timer_two_underflow && ctrl_reg[CTRL_RELOAD_BIT] && ctrl_reg[5:4] == START_TX_END
      |-> timer_two_running;
  endproperty
  a_restart: assert property (p_restart) else $error("stopped despite reload");
  property p_uf_tick; timer_two_underflow && ctrl_reg[1:0] != CLK_SLOW |-> tick_reg; endproperty
  a_uf_tick: assert property (p_uf_tick) else $error("underflow without tick");
  property p_uf_irq; timer_two_underflow && en_reg |-> irq; endproperty
  a_uf_irq: assert property (p_uf_irq) else $error("underflow without irq");
  property p_irq_en; !en_reg |-> !irq; endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  property p_trim_no_uf; ctrl_reg[5:4] == START_TRIM_NO_UF |=> !timer_two_underflow; endproperty
  a_trim_no_uf: assert property (p_trim_no_uf) else $error("underflow in trim");
  c_uf: cover property (timer_two_underflow);
  c_irq: cover property (irq);
  c_run: cover property ($rose(timer_two_running));
endmodule
bind rft_timer_two rft_timer_two_chk u_chk (.*);

/* tb.sv */
// Self-checking bench for timer two
`timescale 1ns/1ps
module tb import rft_pkg::*; ();
  logic clk, rstn, wr_en, rd_en, fast_tick, tx_done, rx_bit_valid, rx_frame_start;
  logic timer0_underflow, timer1_underflow, slow_osc_pin, timer_two_underflow;
  logic timer_two_running, irq, rd_q;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] timer1_count, r;
  logic [31:0] seed = 32'h0000827F;
  logic [7:0] exp_q[$];
  int errors, checks, uf_n, n0;
  rft_timer_two u_dut (
    .clk(clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .fast_tick(fast_tick),
    .tx_done(tx_done),
    .rx_bit_valid(rx_bit_valid),
    .rx_frame_start(rx_frame_start),
    .timer0_underflow(timer0_underflow),
    .timer1_underflow(timer1_underflow),
    .timer1_count(timer1_count),
    .slow_osc_pin(slow_osc_pin),
    .timer_two_underflow(timer_two_underflow),
    .timer_two_running(timer_two_running),
    .irq(irq)
  );
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read strobe; the expected byte waits in the queue for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  task automatic rd16(input logic [15:0] e);
    rd(ADDR_T2_CNT_HI, e[15:8]);
    rd(ADDR_T2_CNT_LO, e[7:0]);
  endtask
  task automatic ld(input logic [15:0] v, input logic [7:0] c);
    wr(ADDR_T2_RELOAD_HI, v[15:8]);
    wr(ADDR_T2_RELOAD_LO, v[7:0]);
    wr(ADDR_T2_CTRL, c);
  endtask
  // Pulses: fast, timer0, timer1, tx end, frame start, rx bit
  task automatic pl(input logic [5:0] s, input int n);
    repeat (n) begin
      @(posedge clk);
      {fast_tick, timer0_underflow, timer1_underflow, tx_done, rx_frame_start, rx_bit_valid} <= s;
      @(posedge clk);
      {fast_tick, timer0_underflow, timer1_underflow, tx_done, rx_frame_start, rx_bit_valid} <= '0;
    end
  endtask
  task automatic osc(input logic v);
    @(posedge clk);
    slow_osc_pin <= v;
    repeat (5) @(posedge clk);
  endtask
  task automatic run_is(input logic v);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (timer_two_running !== v && i < 20);
    cmp({7'h00, timer_two_running}, {7'h00, v});
    if (timer_two_running !== v) final_report();
  endtask
  // Interrupt level, looked at between edges
  task automatic irq_is(input logic v);
    @(negedge clk);
    cmp({7'h00, irq}, {7'h00, v});
  endtask
  // Underflow pulses seen on the output
  always @(posedge clk) begin
    if (timer_two_underflow === 1'b1) uf_n <= uf_n + 1;
  end
  always @(posedge clk) begin
    rd_q <= rd_en;
    if (rd_q === 1'b1) cmp(rdata, exp_q.pop_front());
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    final_report();
  end
  initial begin
    {addr, wdata, wr_en, rd_en, fast_tick, tx_done, rx_bit_valid, rx_frame_start} = '0;
    {timer0_underflow, timer1_underflow, slow_osc_pin, rstn} = '0;
    timer1_count = 16'h0000;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_T2_RELOAD_LO, RELOAD_RESET);
    wr(ADDR_T2_CTRL, 8'hFF);
    rd(ADDR_T2_CTRL, CTRL_WMASK);
    r = rnd();
    ld(r, 8'h00);
    rd(ADDR_T2_RELOAD_HI, r[15:8]);
    rd(ADDR_T2_RELOAD_LO, r[7:0]);
    wr(8'h40, 8'h5A);
    rd(8'h40, 8'h00);
    r = rnd();
    @(posedge clk);
    timer1_count <= r;
    rd(ADDR_T1_CNT_HI, r[15:8]);
    rd(ADDR_T1_CNT_LO, r[7:0]);
    pl(6'h04, 1);
    pl(6'h20, 1);
    rd16(16'h0000);
    $display("done: registers");
    r = rnd() | 16'h0100;
    ld(r, 8'h10);
    pl(6'h04, 1);
    rd16(r);
    pl(6'h20, 3);
    rd16(r - 16'h0003);
    wr(ADDR_T2_RELOAD_HI, ~r[15:8]);
    pl(6'h20, 1);
    rd16(r - 16'h0004);
    pl(6'h04, 1);
    rd16({~r[15:8], r[7:0]});
    $display("done: count");
    n0 = uf_n;
    ld(16'h0002, 8'h10);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    pl(6'h04, 1);
    pl(6'h20, 2);
    rd(ADDR_IRQ_STATUS, 8'h00);
    pl(6'h20, 1);
    rd(ADDR_IRQ_STATUS, 8'h01);
    irq_is(1'b1);
    cmp(8'(uf_n - n0), 8'h01);
    pl(6'h20, 2);
    rd16(16'h0000);
    run_is(1'b0);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    irq_is(1'b0);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h00);
    irq_is(1'b0);
    wr(ADDR_T2_CTRL, 8'h18);
    pl(6'h04, 1);
    pl(6'h20, 3);
    rd16(16'h0002);
    cmp(8'(uf_n - n0), 8'h02);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    $display("done: underflow");
    for (int s = 0; s < 4; s++) begin
      ld(16'h0005, 8'h10 | 8'(s));
      pl(6'h04, 1);
      if (s == 1) pl(6'h20, SLOW_DIV);
      else pl(6'h38, 1);
      rd16(16'h0004);
    end
    $display("done: sources");
    ld(16'h0100, 8'h10);
    pl(6'h04, 1);
    pl(6'h02, 1);
    pl(6'h01, 4);
    pl(6'h20, 1);
    rd16(16'h00FF);
    wr(ADDR_T2_CTRL, 8'h90);
    pl(6'h04, 1);
    pl(6'h02, 1);
    pl(6'h01, 4);
    run_is(1'b0);
    pl(6'h20, 1);
    rd16(16'h0100);
    $display("done: receive halt");
    ld(16'h0010, 8'hA0);
    osc(1'b1);
    run_is(1'b1);
    pl(6'h02, 1);
    pl(6'h01, 4);
    pl(6'h20, 2);
    rd16(16'h000E);
    pl(6'h20, 16);
    rd16(16'h0000);
    rd(ADDR_IRQ_STATUS, 8'h00);
    run_is(1'b1);
    osc(1'b0);
    osc(1'b1);
    run_is(1'b0);
    ld(16'h0001, 8'hB0);
    osc(1'b0);
    osc(1'b1);
    pl(6'h20, 2);
    rd(ADDR_IRQ_STATUS, 8'h01);
    $display("done: trimming");
    repeat (3) @(posedge clk);
    final_report();
  end
endmodule
